/* File: cssr_host.sv */
module cssr_host
(
  // Clock
  input  wire logic        clk,
  // Register port
  output logic [11:0]      reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 12'h000;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // The address is inverted when idle so a stale value is never mistaken for a live one.
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // Read data stand for one cycle only; taking them mid-cycle keeps clear of the edge.
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask : wr
endmodule : cssr_host

/* File: cssr_pkg.sv */
package cssr_pkg;

  localparam logic [11:0] CSSR_OFS_TIME  = 12'h114;
  localparam logic [11:0] CSSR_OFS_RATE  = 12'h118;
  localparam logic [11:0] CSSR_OFS_OFFS  = 12'h11C;
  localparam logic [11:0] CSSR_OFS_SYNC  = 12'h120;
  localparam logic [11:0] CSSR_OFS_SWIN  = 12'h124;
  localparam logic [11:0] CSSR_OFS_FAIL  = 12'h104;

  localparam logic [13:0] CSSR_MT_MAX    = 14'h3E80;
  localparam logic [3:0]  CSSR_SYNC_MAX  = 4'hF;
  localparam logic [3:0]  CSSR_FAIL_MAX  = 4'hF;

  localparam logic [31:0] CSSR_RESET_VAL = 32'h00000000;

  localparam int CSSR_MT_LSB        = 0;
  localparam int CSSR_CYC_LSB       = 16;
  localparam int CSSR_MISS_OFFS_BIT = 16;
  localparam int CSSR_LIM_OFFS_BIT  = 17;
  localparam int CSSR_MISS_RATE_BIT = 18;
  localparam int CSSR_LIM_RATE_BIT  = 19;
  localparam int CSSR_SYN_A_BIT     = 0;
  localparam int CSSR_BND_A_BIT     = 1;
  localparam int CSSR_TXC_A_BIT     = 2;
  localparam int CSSR_SYN_B_BIT     = 3;
  localparam int CSSR_BND_B_BIT     = 4;
  localparam int CSSR_TXC_B_BIT     = 5;

endpackage : cssr_pkg

/* File: cssr_regs.sv */
// Strobed register access was left to the implementer.
module cssr_regs
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Configuration
  input  wire logic        own_sync_tx_enable,
  input  wire logic [10:0] max_rate_correction_bound,
  input  wire logic [13:0] max_offset_correction_bound,
  input  wire logic        in_startup,
  // Cycle timing events
  input  wire logic        cycle_start,
  input  wire logic        macrotick_tick,
  input  wire logic        nit_pulse,
  input  wire logic        cycle_end,
  // Sync frame events
  input  wire logic        sync_frame_a,
  input  wire logic        sync_frame_b,
  // Correction results
  input  wire logic        ocp_start,
  input  wire logic [11:0] rate_correction_term,
  input  wire logic [18:0] offset_correction_term,
  input  wire logic        no_sync_frames,
  input  wire logic        no_sync_pairs,
  input  wire logic [11:0] ext_rate_correction,
  input  wire logic [18:0] ext_offset_correction,
  // Symbol window events
  input  wire logic        symwin_end_a,
  input  wire logic        symwin_end_b,
  input  wire logic        syntax_err_a,
  input  wire logic        syntax_err_b,
  input  wire logic        boundary_viol_a,
  input  wire logic        boundary_viol_b,
  input  wire logic        tx_conflict_a,
  input  wire logic        tx_conflict_b,
  // Applied corrections and status
  output logic [11:0]      applied_rate_correction,
  output logic [18:0]      applied_offset_correction,
  output logic [13:0]      macrotick_value,
  output logic [5:0]       cycle_count_value
);

  // ************************************************************
  // State
  // ************************************************************

  typedef struct packed {
    logic [13:0] mt;
    logic [5:0]  cyc;
    logic [11:0] rate;
    logic [18:0] offs;
    logic [11:0] app_rate;
    logic [18:0] app_offs;
    logic        rate_limit_reached;
    logic        offset_limit_reached;
    logic        missing_rate_correction;
    logic        missing_offset_correction;
    logic [3:0]  correction_failed_counter;
    logic [31:0] rdata;
  } cssr_st_t;

  cssr_st_t s_q;
  cssr_st_t s_d;

  logic [15:0] sync_counts;
  logic [2:0]  sw_a;
  logic [2:0]  sw_b;

  // ************************************************************
  // Sub-blocks
  // ************************************************************

  cssr_sync_count u_sync
  (
    .clk                (clk),
    .rst_n              (rst_n),
    .nit_pulse          (nit_pulse),
    .odd_cycle          (s_q.cyc[0]),
    .own_sync_tx_enable (own_sync_tx_enable),
    .frame_a            (sync_frame_a),
    .frame_b            (sync_frame_b),
    .counts             (sync_counts)
  );

  cssr_symwin u_swa
  (
    .clk           (clk),
    .rst_n         (rst_n),
    .win_end       (symwin_end_a),
    .in_startup    (in_startup),
    .syntax_err    (syntax_err_a),
    .boundary_viol (boundary_viol_a),
    .tx_conflict   (tx_conflict_a),
    .status        (sw_a)
  );

  cssr_symwin u_swb
  (
    .clk           (clk),
    .rst_n         (rst_n),
    .win_end       (symwin_end_b),
    .in_startup    (in_startup),
    .syntax_err    (syntax_err_b),
    .boundary_viol (boundary_viol_b),
    .tx_conflict   (tx_conflict_b),
    .status        (sw_b)
  );

  // ************************************************************
  // Helpers
  // ************************************************************

  // True when a signed value lies outside plus or minus the bound.
  function automatic logic cssr_over(input logic signed [19:0] v, input logic [19:0] b);
    logic signed [19:0] bs;
    bs = $signed(b);
    cssr_over = (v > bs) || (v < -bs);
  endfunction : cssr_over

  // Clamps a signed value to plus or minus the bound.
  function automatic logic signed [19:0] cssr_clamp(input logic signed [19:0] v,
                                                    input logic [19:0] b);
    logic signed [19:0] bs;
    bs = $signed(b);
    if (v > bs)
      cssr_clamp = bs;
    else if (v < -bs)
      cssr_clamp = -bs;
    else
      cssr_clamp = v;
  endfunction : cssr_clamp

  // ************************************************************
  // Next state
  // ************************************************************

  always_comb
  begin
    logic signed [19:0] rv;
    logic signed [19:0] ov;
    logic [19:0]        rb;
    logic [19:0]        ob;
    logic signed [19:0] rc;
    logic signed [19:0] oc;
    s_d = s_q;
    rv  = 20'($signed(rate_correction_term));
    ov  = 20'($signed(offset_correction_term));
    rb  = {9'h000, max_rate_correction_bound};
    ob  = {6'h00, max_offset_correction_bound};
    rc  = cssr_clamp(rv, rb);
    oc  = cssr_clamp(ov, ob);

    if (cycle_start)
    begin
      s_d.mt  = 14'h0000;
      s_d.cyc = s_q.cyc + 6'h01;
    end
    else if (macrotick_tick && s_q.mt != cssr_pkg::CSSR_MT_MAX)
      s_d.mt = s_q.mt + 14'h0001;

    if (ocp_start)
    begin
      s_d.rate = rate_correction_term;
      s_d.offs = offset_correction_term;
      s_d.rate_limit_reached        = cssr_over(rv, rb);
      s_d.offset_limit_reached      = cssr_over(ov, ob);
      s_d.missing_offset_correction = no_sync_frames;
      s_d.missing_rate_correction   = no_sync_pairs;
      // Clamped internal term plus the external term; the bound keeps the clamp in range.
      s_d.app_rate = 12'(rc) + ext_rate_correction;
      s_d.app_offs = 19'(oc) + ext_offset_correction;
    end

    if (cycle_end && s_q.cyc[0])
    begin
      if (s_q.missing_offset_correction || s_q.missing_rate_correction)
      begin
        if (s_q.correction_failed_counter != cssr_pkg::CSSR_FAIL_MAX)
          s_d.correction_failed_counter = s_q.correction_failed_counter + 4'h1;
      end
      else
        s_d.correction_failed_counter = 4'h0;
    end

    // Reads have no side effect and writes change nothing here.
    s_d.rdata = cssr_pkg::CSSR_RESET_VAL;
    if (reg_rd)
    begin
      case (reg_addr)
        cssr_pkg::CSSR_OFS_TIME:
        begin
          s_d.rdata[cssr_pkg::CSSR_MT_LSB +: 14] = s_q.mt;
          s_d.rdata[cssr_pkg::CSSR_CYC_LSB +: 6] = s_q.cyc;
        end
        cssr_pkg::CSSR_OFS_RATE:
          s_d.rdata[11:0] = s_q.rate;
        cssr_pkg::CSSR_OFS_OFFS:
          s_d.rdata[18:0] = s_q.offs;
        cssr_pkg::CSSR_OFS_SYNC:
        begin
          s_d.rdata[15:0] = sync_counts;
          s_d.rdata[cssr_pkg::CSSR_MISS_OFFS_BIT] = s_q.missing_offset_correction;
          s_d.rdata[cssr_pkg::CSSR_LIM_OFFS_BIT]  = s_q.offset_limit_reached;
          s_d.rdata[cssr_pkg::CSSR_MISS_RATE_BIT] = s_q.missing_rate_correction;
          s_d.rdata[cssr_pkg::CSSR_LIM_RATE_BIT]  = s_q.rate_limit_reached;
        end
        cssr_pkg::CSSR_OFS_SWIN:
        begin
          s_d.rdata[cssr_pkg::CSSR_SYN_A_BIT] = sw_a[0];
          s_d.rdata[cssr_pkg::CSSR_BND_A_BIT] = sw_a[1];
          s_d.rdata[cssr_pkg::CSSR_TXC_A_BIT] = sw_a[2];
          s_d.rdata[cssr_pkg::CSSR_SYN_B_BIT] = sw_b[0];
          s_d.rdata[cssr_pkg::CSSR_BND_B_BIT] = sw_b[1];
          s_d.rdata[cssr_pkg::CSSR_TXC_B_BIT] = sw_b[2];
        end
        cssr_pkg::CSSR_OFS_FAIL:
          s_d.rdata[3:0] = s_q.correction_failed_counter;
        default:
          s_d.rdata = cssr_pkg::CSSR_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  assign reg_rdata                 = s_q.rdata;
  assign applied_rate_correction   = s_q.app_rate;
  assign applied_offset_correction = s_q.app_offs;
  assign macrotick_value           = s_q.mt;
  assign cycle_count_value         = s_q.cyc;

endmodule : cssr_regs

/* File: cssr_regs_props.sv */
module cssr_regs_props
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cycle_start,
  input wire logic        macrotick_tick,
  input wire logic        ocp_start,
  input wire logic [10:0] max_rate_correction_bound,
  input wire logic [13:0] max_offset_correction_bound,
  input wire logic [11:0] rate_correction_term,
  input wire logic [18:0] offset_correction_term,
  input wire logic [11:0] ext_rate_correction,
  input wire logic [18:0] ext_offset_correction,
  input wire logic [11:0] applied_rate_correction,
  input wire logic [18:0] applied_offset_correction,
  input wire logic [13:0] macrotick_value,
  input wire logic [5:0]  cycle_count_value
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [19:0] rc_full;
  logic [19:0] oc_full;
  // Clamp a sign-extended term to plus or minus an unsigned bound.
  function automatic logic [19:0] clamp(logic [19:0] t, logic [19:0] b);
    if ($signed(t) > $signed(b))
      return b;
    if ($signed(t) < -$signed(b))
      return -b;
    return t;
  endfunction : clamp
  assign rc_full = clamp({{8{rate_correction_term[11]}}, rate_correction_term},
                         {9'h000, max_rate_correction_bound});
  assign oc_full = clamp({offset_correction_term[18], offset_correction_term},
                         {6'h00, max_offset_correction_bound});
  sequence s_start; cycle_start; endsequence
  sequence s_step; macrotick_tick && !cycle_start && macrotick_value != 14'h3E80; endsequence
  sequence s_ocp; ocp_start; endsequence
  property p_mt_clear; s_start |=> macrotick_value == 14'h0000; endproperty
  property p_mt_step; s_step |=> macrotick_value == $past(macrotick_value) + 14'h0001; endproperty
  property p_mt_max; macrotick_value <= cssr_pkg::CSSR_MT_MAX; endproperty
  property p_cyc_step; s_start |=> cycle_count_value == $past(cycle_count_value) + 6'h01; endproperty
  property p_cyc_hold; !cycle_start |=> $stable(cycle_count_value); endproperty
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h00000000; endproperty
  property p_rate_app;
    s_ocp |=> applied_rate_correction == $past(rc_full[11:0]) + $past(ext_rate_correction);
  endproperty
  property p_offs_app;
    s_ocp |=> applied_offset_correction == $past(oc_full[18:0]) + $past(ext_offset_correction);
  endproperty
  property p_app_hold;
    !ocp_start |=> $stable(applied_rate_correction) && $stable(applied_offset_correction);
  endproperty
  a_mt_clear: assert property (p_mt_clear) else $error("macrotick not cleared");
  a_mt_step: assert property (p_mt_step) else $error("macrotick step wrong");
  a_mt_max: assert property (p_mt_max) else $error("macrotick above limit");
  a_cyc_step: assert property (p_cyc_step) else $error("cycle step wrong");
  a_cyc_hold: assert property (p_cyc_hold) else $error("cycle moved");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rate_app: assert property (p_rate_app) else $error("applied rate wrong");
  a_offs_app: assert property (p_offs_app) else $error("applied offset wrong");
  a_app_hold: assert property (p_app_hold) else $error("applied moved");
endmodule : cssr_regs_props

bind cssr_regs cssr_regs_props i_props (.clk, .rst_n, .reg_rd, .reg_rdata, .cycle_start,
  .macrotick_tick, .ocp_start, .max_rate_correction_bound, .max_offset_correction_bound,
  .rate_correction_term, .offset_correction_term, .ext_rate_correction,
  .ext_offset_correction, .applied_rate_correction, .applied_offset_correction,
  .macrotick_value, .cycle_count_value);

/* File: cssr_symwin.sv */
module cssr_symwin
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Symbol window events of one channel
  input  wire logic       win_end,
  input  wire logic       in_startup,
  input  wire logic       syntax_err,
  input  wire logic       boundary_viol,
  input  wire logic       tx_conflict,
  // Latched status: syntax, boundary, conflict
  output logic [2:0]      status
);

  // ************************************************************
  // Window error capture
  // ************************************************************

  typedef struct packed {
    logic [2:0] seen;
    logic [2:0] stat;
  } cssr_sw_t;

  cssr_sw_t s_q;
  cssr_sw_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.seen = s_q.seen | {tx_conflict, boundary_viol, syntax_err};
    if (win_end)
    begin
      // The window's own last-cycle events still count toward the result.
      if (!in_startup)
        s_d.stat = s_q.seen | {tx_conflict, boundary_viol, syntax_err};
      s_d.seen = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign status = s_q.stat;

endmodule : cssr_symwin

/* File: cssr_sync_count.sv */
module cssr_sync_count
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Cycle events
  input  wire logic       nit_pulse,
  input  wire logic       odd_cycle,
  input  wire logic       own_sync_tx_enable,
  input  wire logic       frame_a,
  input  wire logic       frame_b,
  // Reported counts
  output logic [15:0]     counts
);

  // ************************************************************
  // Per-cycle valid sync frame accumulation
  // ************************************************************

  typedef struct packed {
    logic [3:0] acc_a;
    logic [3:0] acc_b;
    logic [3:0] a_even;
    logic [3:0] a_odd;
    logic [3:0] b_even;
    logic [3:0] b_odd;
  } cssr_sc_t;

  cssr_sc_t s_q;
  cssr_sc_t s_d;

  // Saturation keeps a noisy bus from wrapping the count past its fifteen frame limit.
  function automatic logic [3:0] cssr_sat_inc(input logic [3:0] v, input logic en);
    cssr_sat_inc = (en && v != cssr_pkg::CSSR_SYNC_MAX) ? v + 4'h1 : v;
  endfunction : cssr_sat_inc

  always_comb
  begin
    logic [3:0] fa;
    logic [3:0] fb;
    s_d = s_q;
    fa  = cssr_sat_inc(s_q.acc_a, own_sync_tx_enable);
    fb  = cssr_sat_inc(s_q.acc_b, own_sync_tx_enable);
    s_d.acc_a = cssr_sat_inc(s_q.acc_a, frame_a);
    s_d.acc_b = cssr_sat_inc(s_q.acc_b, frame_b);
    if (nit_pulse)
    begin
      s_d.acc_a = 4'h0;
      s_d.acc_b = 4'h0;
      if (odd_cycle)
      begin
        s_d.a_odd = fa;
        s_d.b_odd = fb;
      end
      else
      begin
        s_d.a_even = fa;
        s_d.b_even = fb;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign counts = {s_q.b_odd, s_q.b_even, s_q.a_odd, s_q.a_even};

endmodule : cssr_sync_count

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] rt; logic [18:0] ot; logic nf; logic np; logic [3:0] fl;}
    cssr_row_t;
  typedef enum int {EV_OCP, EV_CEND, EV_CSTART, EV_TICK, EV_SFA, EV_SFB, EV_NIT, EV_SWA}
    cssr_ev_t;
  logic clk, rst_n, reg_wr, reg_rd, own_sync_tx_enable, in_startup, cycle_start, macrotick_tick;
  logic nit_pulse, cycle_end, sync_frame_a, sync_frame_b, ocp_start, no_sync_frames;
  logic no_sync_pairs, symwin_end_a, symwin_end_b, syntax_err_a, syntax_err_b;
  logic boundary_viol_a, boundary_viol_b, tx_conflict_a, tx_conflict_b;
  logic [11:0] reg_addr, rate_correction_term, ext_rate_correction;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [18:0] offset_correction_term, ext_offset_correction;
  logic [10:0] max_rate_correction_bound;
  logic [13:0] max_offset_correction_bound;
  int err_count, check_count;
  // Bounds are 100 and 200; flags nibble is {rate limit, missing rate, offset limit, missing offset}.
  cssr_row_t rows [6] = '{'{12'h050, 19'h00064, 1'b0, 1'b0, 4'h0},
    '{12'h065, 19'h00000, 1'b0, 1'b0, 4'h8}, '{12'hF9B, 19'h7FF37, 1'b0, 1'b0, 4'hA},
    '{12'h064, 19'h000C8, 1'b0, 1'b0, 4'h0}, '{12'h000, 19'h00000, 1'b0, 1'b1, 4'h4},
    '{12'hF9C, 19'h7FF38, 1'b1, 1'b1, 4'h5}};
  logic [11:0] addrs [7] = '{12'h104, 12'h114, 12'h118, 12'h11C, 12'h120, 12'h124, 12'h200};
  cssr_host i_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  cssr_regs i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .own_sync_tx_enable, .max_rate_correction_bound, .max_offset_correction_bound, .in_startup,
    .cycle_start, .macrotick_tick, .nit_pulse, .cycle_end, .sync_frame_a, .sync_frame_b,
    .ocp_start, .rate_correction_term, .offset_correction_term, .no_sync_frames, .no_sync_pairs,
    .ext_rate_correction, .ext_offset_correction, .symwin_end_a, .symwin_end_b, .syntax_err_a,
    .syntax_err_b, .boundary_viol_a, .boundary_viol_b, .tx_conflict_a, .tx_conflict_b,
    .applied_rate_correction(), .applied_offset_correction(), .macrotick_value(),
    .cycle_count_value());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Event strobes are picked by name, so one task drives all but symwin_end_b without a ref argument.
  task automatic drive_ev(input cssr_ev_t e, input logic v);
    case (e)
      EV_OCP:    ocp_start <= v;
      EV_CEND:   cycle_end <= v;
      EV_CSTART: cycle_start <= v;
      EV_TICK:   macrotick_tick <= v;
      EV_SFA:    sync_frame_a <= v;
      EV_SFB:    sync_frame_b <= v;
      EV_NIT:    nit_pulse <= v;
      default:   symwin_end_a <= v;
    endcase
  endtask : drive_ev
  task automatic pulse(input cssr_ev_t e);
    @(posedge clk);
    drive_ev(e, 1'b1);
    @(posedge clk);
    drive_ev(e, 1'b0);
  endtask : pulse
  task automatic ocp_run(input cssr_row_t r);
    @(posedge clk);
    rate_correction_term <= r.rt;
    offset_correction_term <= r.ot;
    no_sync_frames <= r.nf;
    no_sync_pairs <= r.np;
    ext_rate_correction <= ext_rate_correction + 12'h003;
    ext_offset_correction <= ext_offset_correction - 19'h00005;
    pulse(EV_OCP);
  endtask : ocp_run
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    {rst_n, own_sync_tx_enable, in_startup, cycle_start, macrotick_tick, nit_pulse} = '0;
    {cycle_end, sync_frame_a, sync_frame_b, ocp_start, no_sync_frames, no_sync_pairs} = '0;
    {symwin_end_a, symwin_end_b, syntax_err_a, syntax_err_b, boundary_viol_a} = '0;
    {boundary_viol_b, tx_conflict_a, tx_conflict_b} = '0;
    {rate_correction_term, offset_correction_term} = '0;
    {ext_rate_correction, ext_offset_correction} = '0;
    max_rate_correction_bound = 11'h064;
    max_offset_correction_bound = 14'h00C8;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      ocp_run(rows[i]);
      i_host.rd(12'h118, d);
      check(d, {20'h00000, rows[i].rt});
      i_host.rd(12'h11C, d);
      check(d, {13'h0000, rows[i].ot});
      i_host.rd(12'h120, d);
      check({28'h0, d[19:16]}, {28'h0, rows[i].fl});
    end
    $display("test rows done");
    i_host.wr(12'h118, 32'hFFFFFFFF);
    i_host.rd(12'h118, d);
    check(d, 32'h00000F9C);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (addrs[i])
    begin
      i_host.rd(addrs[i], d);
      check(d, 32'h00000000);
    end
    $display("test reset done");
    ocp_run(rows[5]);
    pulse(EV_CEND);
    i_host.rd(12'h104, d);
    check(d, 32'h00000000);
    pulse(EV_CSTART);
    repeat (17) pulse(EV_CEND);
    i_host.rd(12'h104, d);
    check(d, 32'h0000000F);
    ocp_run(rows[0]);
    pulse(EV_CEND);
    i_host.rd(12'h104, d);
    check(d, 32'h00000000);
    $display("test failed counter done");
    @(posedge clk);
    macrotick_tick <= 1'b1;
    repeat (16005) @(posedge clk);
    macrotick_tick <= 1'b0;
    i_host.rd(12'h114, d);
    check(d, 32'h00013E80);
    pulse(EV_CSTART);
    pulse(EV_TICK);
    i_host.rd(12'h114, d);
    check(d, 32'h00020001);
    repeat (62) pulse(EV_CSTART);
    i_host.rd(12'h114, d);
    check(d, 32'h00000000);
    $display("test counters done");
    // Both channels count as assigned here, so every field is meaningful.
    own_sync_tx_enable <= 1'b1;
    repeat (3) pulse(EV_SFA);
    repeat (16) pulse(EV_SFB);
    pulse(EV_NIT);
    own_sync_tx_enable <= 1'b0;
    pulse(EV_CSTART);
    pulse(EV_SFA);
    pulse(EV_NIT);
    i_host.rd(12'h120, d);
    check({16'h0000, d[15:0]}, 32'h00000F14);
    $display("test sync counts done");
    @(posedge clk);
    in_startup <= 1'b1;
    syntax_err_a <= 1'b1;
    pulse(EV_SWA);
    i_host.rd(12'h124, d);
    check(d, 32'h00000000);
    in_startup <= 1'b0;
    tx_conflict_a <= 1'b1;
    boundary_viol_b <= 1'b1;
    symwin_end_b <= 1'b1;
    pulse(EV_SWA);
    symwin_end_b <= 1'b0;
    {syntax_err_a, tx_conflict_a, boundary_viol_b} <= 3'h0;
    i_host.rd(12'h124, d);
    check(d, 32'h00000015);
    pulse(EV_SWA);
    i_host.rd(12'h124, d);
    check(d, 32'h00000010);
    // The remaining three flags, so that every status bit position is seen set once.
    {boundary_viol_a, syntax_err_b, tx_conflict_b} <= 3'h7;
    symwin_end_b <= 1'b1;
    pulse(EV_SWA);
    symwin_end_b <= 1'b0;
    {boundary_viol_a, syntax_err_b, tx_conflict_b} <= 3'h0;
    i_host.rd(12'h124, d);
    check(d, 32'h0000002A);
    $display("test symbol window done");
    give_verdict();
  end
endmodule : tb
